// >>> pkg/gcs_defines.svh
`ifndef GCS_DEFINES_SVH
`define GCS_DEFINES_SVH

// ----------------------------------------
// Process data addressing
// ----------------------------------------
`define GCS_ADDR_W          10
`define GCS_STATUS_BASE     10'h000
`define GCS_CTRL_BASE       10'h200

// ----------------------------------------
// Status word fields
// ----------------------------------------
`define GCS_SR_SEND_BIT     15
`define GCS_SR_CONFIRM_BIT  14
`define GCS_SR_VALID_BIT    13
`define GCS_SR_CODE_MSB     12
`define GCS_SR_CODE_LSB     8
`define GCS_SR_DATA_MSB     7
`define GCS_SR_DATA_LSB     0

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define GCS_CR_SEND_BIT     15
`define GCS_CR_CONFIRM_BIT  14
`define GCS_CR_VALID_BIT    13
`define GCS_CR_DATA_MSB     12
`define GCS_CR_DATA_LSB     0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GCS_WORD_RESET      16'h0000
`define GCS_CODE_RESET      5'h1f
`define GCS_BYTE_RESET      8'h00

`endif

// >>> pkg/gcs_pkg.sv
package gcs_pkg;

    // Control and status word enable setting
    typedef enum logic [1:0]
    {
        GCS_CW_DISABLED,
        GCS_CW_ENABLED,
        GCS_CW_NO_LOCK
    } gcs_cw_mode_type;

    // Sub-network protocol mode
    typedef enum logic
    {
        GCS_PROTO_MASTER,
        GCS_PROTO_GENERIC
    } gcs_proto_type;

    // Fieldbus participation state
    typedef enum logic [1:0]
    {
        GCS_ST_OFFLINE,
        GCS_ST_ONLINE_IDLE,
        GCS_ST_EXCHANGING
    } gcs_link_state_type;

endpackage

// >>> pkg/gcs_fb_if.sv
`timescale 1ns/10ps
`include "gcs_defines.svh"

interface gcs_fb_if;
    logic [`GCS_ADDR_W-1:0] addr;
    logic                   rdEn;
    logic                   wrEn;
    logic [7:0]             wrData;

    modport source
    (
        output addr,
        output rdEn,
        output wrEn,
        output wrData
    );

    modport lane
    (
        input addr,
        input rdEn,
        input wrEn,
        input wrData
    );
endinterface

// >>> design/gcs_word_lane.sv
`timescale 1ns/10ps
`include "gcs_defines.svh"

module gcs_word_lane
#(
    parameter logic [`GCS_ADDR_W-1:0] BASE = `GCS_STATUS_BASE
)
(
    gcs_fb_if.lane          busIf,
    input  wire logic       laneEnable,
    output wire logic       hitHigh,
    output wire logic       hitLow
);
    // ----------------------------------------
    // Byte decode, most significant byte first
    // ----------------------------------------
    assign hitHigh = laneEnable && (busIf.addr == BASE);
    assign hitLow  = laneEnable && (busIf.addr == (BASE + `GCS_ADDR_W'(1)));
endmodule

// >>> design/gcs_ctrl_status.sv
`timescale 1ns/10ps
`include "gcs_defines.svh"

// Operation
// - Words stay off after defaults; only the configuration setting turns them on.
// - Status word at input bytes 0-1, control word at output bytes 0-1.
// - Both words held most significant byte first.
// - Both sides follow the handshake when accessing the words.
// - Enabled with startup lock: no sub-network exchange until host data-valid set.
// - Disabled or no-lock: sub-network starts as soon as fieldbus is online.
// - While exchanging, data both ways is valid and exchanged continuously.
// - Gateway never clears its data-valid bit on its own once set.
// - Gateway data-valid may be delayed by missing or slow nodes.
// - Status bit 13 set once all transactions succeeded, master mode only.
// - Status bits 15 and 14 are gateway send and confirm flags.
// - Status bits 12..8 hold last status code, bits 7..0 its data.
module gcs_ctrl_status
    import gcs_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  gcs_pkg::gcs_cw_mode_type         configurationTool,
    input  gcs_pkg::gcs_proto_type           protoMode,
    input  wire logic                        fieldbusOnline,
    input  wire logic [`GCS_ADDR_W-1:0]      fbAddr,
    input  wire logic                        fbRdEn,
    input  wire logic                        fbWrEn,
    input  wire logic [7:0]                  fbWrData,
    output logic      [7:0]                  fbRdData,
    output logic                             fbRdValid,
    output logic                             fbHit,
    input  wire logic                        allTransDone,
    input  wire logic                        repValid,
    input  wire logic [4:0]                  repCode,
    input  wire logic [7:0]                  repData,
    output logic                             repReady,
    output logic                             ctrlRepValid,
    output logic      [12:0]                 ctrlRepData,
    output logic                             subnetEnable,
    output gcs_pkg::gcs_link_state_type      linkState,
    output logic      [15:0]                 ctrlWord
);
    import gcs_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    gcs_fb_if fbBus ();

    logic               wordsOn;
    logic               lockOn;
    logic               stHigh;
    logic               stLow;
    logic               crHigh;
    logic               crLow;
    logic [15:0]        statusWord;

    logic               srSend_q;
    logic               srSend_d;
    logic               srConfirm_q;
    logic               srConfirm_d;
    logic               srValid_q;
    logic               srValid_d;
    logic [4:0]         srCode_q;
    logic [4:0]         srCode_d;
    logic [7:0]         srData_q;
    logic [7:0]         srData_d;
    logic [15:0]        ctrlWord_q;
    logic [15:0]        ctrlWord_d;

    logic [7:0]         rdData_q;
    logic [7:0]         rdData_d;
    logic               rdValid_q;
    logic               rdValid_d;
    logic               hit_q;
    logic               hit_d;

    logic               repReady_q;
    logic               repReady_d;
    logic               ctrlRepValid_q;
    logic               ctrlRepValid_d;
    logic [12:0]        ctrlRepData_q;
    logic [12:0]        ctrlRepData_d;

    gcs_link_state_type state_q;
    gcs_link_state_type state_d;
    logic               subnetEnable_q;
    logic               subnetEnable_d;

    // ----------------------------------------
    // Bus carrier and byte decode
    // ----------------------------------------
    assign fbBus.addr   = fbAddr;
    assign fbBus.rdEn   = fbRdEn;
    assign fbBus.wrEn   = fbWrEn;
    assign fbBus.wrData = fbWrData;

    assign wordsOn = (configurationTool != GCS_CW_DISABLED);
    assign lockOn  = (configurationTool == GCS_CW_ENABLED);

    gcs_word_lane
    #(
        .BASE       (`GCS_STATUS_BASE)
    )
    u_status_lane
    (
        .busIf      (fbBus.lane),
        .laneEnable (wordsOn),
        .hitHigh    (stHigh),
        .hitLow     (stLow)
    );

    gcs_word_lane
    #(
        .BASE       (`GCS_CTRL_BASE)
    )
    u_ctrl_lane
    (
        .busIf      (fbBus.lane),
        .laneEnable (wordsOn),
        .hitHigh    (crHigh),
        .hitLow     (crLow)
    );

    always_comb
    begin
        statusWord                                      = `GCS_WORD_RESET;
        statusWord[`GCS_SR_SEND_BIT]                    = srSend_q;
        statusWord[`GCS_SR_CONFIRM_BIT]                 = srConfirm_q;
        statusWord[`GCS_SR_VALID_BIT]                   = srValid_q;
        statusWord[`GCS_SR_CODE_MSB:`GCS_SR_CODE_LSB]   = srCode_q;
        statusWord[`GCS_SR_DATA_MSB:`GCS_SR_DATA_LSB]   = srData_q;
    end

    // ----------------------------------------
    // Fieldbus byte access
    // ----------------------------------------
    always_comb
    begin
        rdData_d   = `GCS_BYTE_RESET;
        rdValid_d  = fbRdEn;
        hit_d      = (fbRdEn || fbWrEn) && (stHigh || stLow || crHigh || crLow);
        ctrlWord_d = ctrlWord_q;
        if (fbRdEn)
        begin
            if (stHigh)
            begin
                rdData_d = statusWord[15:8];
            end
            else if (stLow)
            begin
                rdData_d = statusWord[7:0];
            end
            else if (crHigh)
            begin
                rdData_d = ctrlWord_q[15:8];
            end
            else if (crLow)
            begin
                rdData_d = ctrlWord_q[7:0];
            end
        end
        if (fbWrEn && crHigh)
        begin
            ctrlWord_d[15:8] = fbWrData;
        end
        if (fbWrEn && crLow)
        begin
            ctrlWord_d[7:0] = fbWrData;
        end
        if (!wordsOn)
        begin
            ctrlWord_d = `GCS_WORD_RESET;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdData_q   <= `GCS_BYTE_RESET;
            rdValid_q  <= 1'b0;
            hit_q      <= 1'b0;
            ctrlWord_q <= `GCS_WORD_RESET;
        end
        else
        begin
            rdData_q   <= rdData_d;
            rdValid_q  <= rdValid_d;
            hit_q      <= hit_d;
            ctrlWord_q <= ctrlWord_d;
        end
    end

    // ----------------------------------------
    // Status report and control report handshake
    // ----------------------------------------
    always_comb
    begin
        srSend_d       = srSend_q;
        srConfirm_d    = srConfirm_q;
        srCode_d       = srCode_q;
        srData_d       = srData_q;
        ctrlRepValid_d = 1'b0;
        ctrlRepData_d  = ctrlRepData_q;
        // Host has mirrored our send flag: slot free
        repReady_d     = wordsOn && (ctrlWord_d[`GCS_CR_CONFIRM_BIT] == srSend_d);
        if (repValid && repReady_q)
        begin
            srCode_d   = repCode;
            srData_d   = repData;
            srSend_d   = ~srSend_q;
            repReady_d = 1'b0;
        end
        // Host posted a new control report
        if (wordsOn && (ctrlWord_q[`GCS_CR_SEND_BIT] != srConfirm_q))
        begin
            ctrlRepValid_d = 1'b1;
            ctrlRepData_d  = ctrlWord_q[`GCS_CR_DATA_MSB:`GCS_CR_DATA_LSB];
            srConfirm_d    = ctrlWord_q[`GCS_CR_SEND_BIT];
        end
        if (!wordsOn)
        begin
            srSend_d    = 1'b0;
            srConfirm_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            srSend_q       <= 1'b0;
            srConfirm_q    <= 1'b0;
            srCode_q       <= `GCS_CODE_RESET;
            srData_q       <= `GCS_BYTE_RESET;
            repReady_q     <= 1'b0;
            ctrlRepValid_q <= 1'b0;
            ctrlRepData_q  <= 13'h0000;
        end
        else
        begin
            srSend_q       <= srSend_d;
            srConfirm_q    <= srConfirm_d;
            srCode_q       <= srCode_d;
            srData_q       <= srData_d;
            repReady_q     <= repReady_d;
            ctrlRepValid_q <= ctrlRepValid_d;
            ctrlRepData_q  <= ctrlRepData_d;
        end
    end

    // ----------------------------------------
    // Data-valid state machine
    // ----------------------------------------
    always_comb
    begin
        state_d        = state_q;
        srValid_d      = srValid_q;
        subnetEnable_d = subnetEnable_q;
        case (state_q)
            GCS_ST_OFFLINE:
            begin
                srValid_d      = 1'b0;
                subnetEnable_d = 1'b0;
                if (fieldbusOnline)
                begin
                    state_d = GCS_ST_ONLINE_IDLE;
                    if (!lockOn)
                    begin
                        subnetEnable_d = 1'b1;
                    end
                end
            end
            GCS_ST_ONLINE_IDLE:
            begin
                if (!lockOn || ctrlWord_q[`GCS_CR_VALID_BIT])
                begin
                    subnetEnable_d = 1'b1;
                end
                // Set only after every transaction has run once
                if (subnetEnable_q && allTransDone && (protoMode == GCS_PROTO_MASTER)
                    && wordsOn)
                begin
                    srValid_d = 1'b1;
                    state_d   = GCS_ST_EXCHANGING;
                end
            end
            GCS_ST_EXCHANGING:
            begin
                srValid_d      = srValid_q;
                subnetEnable_d = 1'b1;
            end
            default:
            begin
                state_d = GCS_ST_OFFLINE;
            end
        endcase
        // Fieldbus loss is the only way out of the online states
        if (!fieldbusOnline)
        begin
            state_d        = GCS_ST_OFFLINE;
            srValid_d      = 1'b0;
            subnetEnable_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q        <= GCS_ST_OFFLINE;
            srValid_q      <= 1'b0;
            subnetEnable_q <= 1'b0;
        end
        else
        begin
            state_q        <= state_d;
            srValid_q      <= srValid_d;
            subnetEnable_q <= subnetEnable_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign fbRdData     = rdData_q;
    assign fbRdValid    = rdValid_q;
    assign fbHit        = hit_q;
    assign repReady     = repReady_q;
    assign ctrlRepValid = ctrlRepValid_q;
    assign ctrlRepData  = ctrlRepData_q;
    assign subnetEnable = subnetEnable_q;
    assign linkState    = state_q;
    assign ctrlWord     = ctrlWord_q;
endmodule

// >>> bench/gcs_ctrl_status_checker.sv
`timescale 1ns/10ps
`include "gcs_defines.svh"

module gcs_ctrl_status_checker
    import gcs_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input gcs_pkg::gcs_cw_mode_type  configurationTool,
    input gcs_pkg::gcs_proto_type    protoMode,
    input wire logic                 fieldbusOnline,
    input wire logic [9:0]           fbAddr,
    input wire logic                 fbRdEn,
    input wire logic                 fbWrEn,
    input wire logic [7:0]           fbWrData,
    input wire logic                 fbRdValid,
    input wire logic                 fbHit,
    input wire logic                 allTransDone,
    input wire logic                 repValid,
    input wire logic                 repReady,
    input wire logic                 ctrlRepValid,
    input wire logic [12:0]          ctrlRepData,
    input wire logic                 subnetEnable,
    input gcs_pkg::gcs_link_state_type linkState,
    input wire logic [15:0]          ctrlWord
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    wire logic wordsOn = configurationTool != GCS_CW_DISABLED;

    sequence seqWrHi;
        fbWrEn && fbAddr == 10'h200 && wordsOn;
    endsequence
    sequence seqWrLo;
        fbWrEn && fbAddr == 10'h201 && wordsOn;
    endsequence
    sequence seqAllDone;
        linkState == GCS_ST_ONLINE_IDLE && subnetEnable && allTransDone && fieldbusOnline
            && protoMode == GCS_PROTO_MASTER && wordsOn;
    endsequence

    AST_RD_ANSWER: assert property (fbRdEn |=> fbRdValid)
        else $error("read not answered");
    AST_OFF_NO_HIT: assert property ((fbRdEn || fbWrEn) && !wordsOn |=> !fbHit)
        else $error("hit while words off");
    AST_CTRL_HI: assert property (seqWrHi |=> ctrlWord[15:8] == $past(fbWrData))
        else $error("control high byte wrong");
    AST_CTRL_LO: assert property (seqWrLo |=> ctrlWord[7:0] == $past(fbWrData))
        else $error("control low byte wrong");
    AST_LOCK: assert property (configurationTool == GCS_CW_ENABLED && !ctrlWord[13]
        && !subnetEnable |=> !subnetEnable) else $error("lock broken");
    AST_NOLOCK: assert property (configurationTool != GCS_CW_ENABLED && fieldbusOnline
        && linkState == GCS_ST_OFFLINE |=> subnetEnable) else $error("start late");
    AST_EXCH: assert property (seqAllDone |=> linkState == GCS_ST_EXCHANGING)
        else $error("exchange not entered");
    AST_STICKY: assert property (linkState == GCS_ST_EXCHANGING && fieldbusOnline
        && wordsOn |=> linkState == GCS_ST_EXCHANGING) else $error("valid dropped");
    AST_DROP: assert property (!fieldbusOnline |=> linkState == GCS_ST_OFFLINE && !subnetEnable)
        else $error("offline ignored");
    AST_REP_TAKEN: assert property (repValid && repReady |=> !repReady)
        else $error("ready after report");
    AST_CTRL_REP: assert property (ctrlRepValid |-> ctrlRepData == $past(ctrlWord[12:0]))
        else $error("control report data");
    AST_GENERIC: assert property (protoMode == GCS_PROTO_GENERIC
        && linkState != GCS_ST_EXCHANGING |=> linkState != GCS_ST_EXCHANGING) else $error("generic");
endmodule

bind gcs_ctrl_status gcs_ctrl_status_checker chk (.clk(clk), .sys_rst(sys_rst),
    .configurationTool(configurationTool), .protoMode(protoMode),
    .fieldbusOnline(fieldbusOnline), .fbAddr(fbAddr), .fbRdEn(fbRdEn), .fbWrEn(fbWrEn),
    .fbWrData(fbWrData), .fbRdValid(fbRdValid), .fbHit(fbHit), .allTransDone(allTransDone),
    .repValid(repValid), .repReady(repReady), .ctrlRepValid(ctrlRepValid),
    .ctrlRepData(ctrlRepData), .subnetEnable(subnetEnable), .linkState(linkState),
    .ctrlWord(ctrlWord));

// >>> bench/gcs_host_model.sv
`timescale 1ns/10ps

module gcs_host_model
(
    input  wire logic        clk,
    output logic [9:0]       fbAddr,
    output logic             fbRdEn,
    output logic             fbWrEn,
    output logic [7:0]       fbWrData,
    input  wire logic [7:0]  fbRdData,
    input  wire logic        fbHit
);
    // ----------------------------------------
    // Control system side of the words
    // ----------------------------------------
    logic [15:0] shadow = 16'h0000;

    initial
    begin
        fbAddr = 10'h3ff;
        fbRdEn = 1'b0;
        fbWrEn = 1'b0;
        fbWrData = 8'hff;
    end

    // Held through the taking edge, then released to inverted values
    task automatic access(input logic wr, input logic [9:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic h);
        @(posedge clk);
        #1;
        fbAddr = a;
        fbWrData = d;
        fbWrEn = wr;
        fbRdEn = !wr;
        @(posedge clk);
        #1;
        fbRdEn = 1'b0;
        fbWrEn = 1'b0;
        fbAddr = ~a;
        fbWrData = ~d;
        q = fbRdData;
        h = fbHit;
    endtask

    // Low byte first, send flag last
    task automatic wrWord(input logic [9:0] a, input logic [15:0] w);
        logic [7:0] q;
        logic       h;
        if (a == 10'h200)
            shadow = w;
        access(1'b1, a + 10'h001, w[7:0], q, h);
        access(1'b1, a, w[15:8], q, h);
    endtask

    task automatic rdWord(input logic [9:0] a, output logic [15:0] w, output logic h);
        logic h2;
        access(1'b0, a, 8'h00, w[15:8], h);
        access(1'b0, a + 10'h001, 8'h00, w[7:0], h2);
    endtask

    // Mirror the gateway send flag into our confirm flag
    task automatic confirm();
        logic [15:0] s;
        logic        h;
        rdWord(10'h000, s, h);
        wrWord(10'h200, {shadow[15], s[15], shadow[13:0]});
    endtask

    // Offline entry, then raise data valid once gateway valid is clear
    task automatic startup();
        logic [15:0] s;
        logic        h;
        wrWord(10'h200, shadow & 16'hdfff);
        s = 16'hffff;
        for (int i = 0; i < 8 && s[13] !== 1'b0; i++)
            rdWord(10'h000, s, h);
        wrWord(10'h200, shadow | 16'h2000);
    endtask
endmodule

// >>> bench/gcs_ctrl_status_test.sv
`timescale 1ns/10ps

module gcs_ctrl_status_test;
    import gcs_pkg::*;
    // ----------------------------------------
    // Stimulus and instances
    // ----------------------------------------
    logic clk, sys_rst, online, allDone, repValid, h;
    gcs_cw_mode_type cfg;
    gcs_proto_type   proto;
    logic [4:0]  repCode;
    logic [7:0]  repData, b;
    logic [15:0] w;
    wire logic [9:0]  fbAddr;
    wire logic [7:0]  fbWrData, fbRdData;
    wire logic [12:0] ctrlRepData;
    wire logic [15:0] ctrlWord;
    wire logic fbRdEn, fbWrEn, fbRdValid, fbHit, repReady, ctrlRepValid, subnetEnable;
    gcs_link_state_type linkState;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;

    gcs_ctrl_status dut (.clk(clk), .sys_rst(sys_rst), .configurationTool(cfg),
        .protoMode(proto), .fieldbusOnline(online), .fbAddr(fbAddr), .fbRdEn(fbRdEn),
        .fbWrEn(fbWrEn), .fbWrData(fbWrData), .fbRdData(fbRdData), .fbRdValid(fbRdValid),
        .fbHit(fbHit), .allTransDone(allDone), .repValid(repValid), .repCode(repCode),
        .repData(repData), .repReady(repReady), .ctrlRepValid(ctrlRepValid),
        .ctrlRepData(ctrlRepData), .subnetEnable(subnetEnable), .linkState(linkState),
        .ctrlWord(ctrlWord));
    gcs_host_model host (.clk(clk), .fbAddr(fbAddr), .fbRdEn(fbRdEn), .fbWrEn(fbWrEn),
        .fbWrData(fbWrData), .fbRdData(fbRdData), .fbHit(fbHit));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic testDisabled();
        check(linkState, GCS_ST_OFFLINE, "reset state");
        host.rdWord(10'h000, w, h);
        check({w, h}, {16'h0000, 1'b0}, "off read");
        host.wrWord(10'h200, 16'h2000);
        check(ctrlWord, 16'h0000, "off write");
        online = 1'b1;
        tick(1);
        check({linkState, subnetEnable}, {GCS_ST_ONLINE_IDLE, 1'b1}, "start");
        online = 1'b0;
        tick(1);
        check(subnetEnable, 1'b0, "stop");
    endtask

    task automatic testRegisters();
        cfg = GCS_CW_ENABLED;
        host.rdWord(10'h000, w, h);
        check({w, h}, {16'h1f00, 1'b1}, "status reset");
        host.wrWord(10'h200, 16'h0123);
        check(ctrlWord, 16'h0123, "ctrl write");
        host.access(1'b0, 10'h200, 8'h00, b, h);
        check(b, 8'h01, "msb first");
        host.access(1'b1, 10'h001, 8'hff, b, h);
        host.rdWord(10'h000, w, h);
        check(w, 16'h1f00, "status read only");
        host.access(1'b0, 10'h002, 8'h00, b, h);
        check(h, 1'b0, "unmapped");
        host.wrWord(10'h200, 16'h0000);
    endtask

    task automatic testLock();
        online = 1'b1;
        tick(4);
        check({linkState, subnetEnable}, {GCS_ST_ONLINE_IDLE, 1'b0}, "lock");
        host.startup();
        for (int i = 0; i < 4 && subnetEnable !== 1'b1; i++)
            tick(1);
        check(subnetEnable, 1'b1, "unlock");
        allDone = 1'b1;
        tick(1);
        allDone = 1'b0;
        check(linkState, GCS_ST_EXCHANGING, "exchange");
        tick(5);
        host.rdWord(10'h000, w, h);
        check(w[13], 1'b1, "valid held");
        online = 1'b0;
        tick(1);
        check(linkState, GCS_ST_OFFLINE, "drop");
        host.rdWord(10'h000, w, h);
        check(w[13], 1'b0, "valid cleared");
    endtask

    task automatic testNoLock();
        cfg = GCS_CW_NO_LOCK;
        proto = GCS_PROTO_GENERIC;
        host.wrWord(10'h200, 16'h0000);
        online = 1'b1;
        allDone = 1'b1;
        tick(1);
        check(subnetEnable, 1'b1, "no lock start");
        tick(3);
        check(linkState, GCS_ST_ONLINE_IDLE, "generic idle");
        allDone = 1'b0;
        proto = GCS_PROTO_MASTER;
        online = 1'b0;
        tick(1);
    endtask

    task automatic testReports();
        cfg = GCS_CW_ENABLED;
        for (int i = 0; i < 4 && repReady !== 1'b1; i++)
            tick(1);
        check(repReady, 1'b1, "ready");
        repCode = 5'h02;
        repData = 8'h5a;
        repValid = 1'b1;
        tick(1);
        check(repReady, 1'b0, "taken");
        repCode = 5'h04;
        tick(1);
        repValid = 1'b0;
        host.rdWord(10'h000, w, h);
        check(w, 16'h825a, "report word");
        host.confirm();
        for (int i = 0; i < 4 && repReady !== 1'b1; i++)
            tick(1);
        check(repReady, 1'b1, "confirmed");
        host.wrWord(10'h200, 16'hca34);
        for (int i = 0; i < 4 && ctrlRepValid !== 1'b1; i++)
            tick(1);
        check({ctrlRepValid, 2'b00, ctrlRepData}, 16'h8a34, "ctrl report");
        host.rdWord(10'h000, w, h);
        check(w, 16'hc25a, "mirror");
    endtask

    initial
    begin
        sys_rst = 1'b1;
        cfg = GCS_CW_DISABLED;
        proto = GCS_PROTO_MASTER;
        online = 1'b0;
        allDone = 1'b0;
        repValid = 1'b0;
        repCode = 5'h00;
        repData = 8'h00;
        repeat (6) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        testDisabled();
        testRegisters();
        testLock();
        testNoLock();
        testReports();
        wrap_up();
    end
endmodule
